// file: pkg/urc_defs.svh
// Constants of the reference clock and reset control block
`ifndef URC_DEFS_SVH
`define URC_DEFS_SVH
`define URC_CLK_HZ 40000000
`define URC_RST_MIN_NS 1000
`define URC_RST_MIN_CYC ((`URC_RST_MIN_NS * (`URC_CLK_HZ / 1000000) + 999) / 1000)
`define URC_LOCK_TICKS 16
`define URC_LOSS_CYC 8
`define URC_SETTLE_CYC 8
`define URC_REFERENCE_CLOCK_INPUT_DIV 2
`define URC_WAKE_CYC 4
`define URC_UART_LVL_RST 2'h0
`define URC_BUS_IDLE 8'h00
`endif

// file: pkg/urc_pkg.sv
// Types of the reference clock and reset control block
package urc_pkg;
  typedef enum logic [2:0] {
    DEV_RESET,
    DEV_SETTLE,
    DEV_LOCK,
    DEV_STPWAIT,
    DEV_RUN,
    DEV_LOWPWR
  } urc_dev_state_t;
  typedef enum logic [2:0] {
    LNK_HOLD,
    LNK_START,
    LNK_IDLE,
    LNK_READY,
    LNK_STOPPED,
    LNK_WAKE
  } urc_lnk_state_t;
  typedef logic [1:0] urc_level_t;
  typedef logic [7:0] urc_byte_t;
endpackage : urc_pkg

// file: pkg/urc_if.sv
// Pins between transceiver and link
`timescale 1ns/100ps
interface urc_if;
  import urc_pkg::*;
  logic active_low_chip_reset_pin_n;
  logic reference_clock_input;
  logic stp;
  logic dir;
  urc_byte_t link_data;
  logic link_data_oe;
  logic strap_tie;
  logic dev_clk;
  logic dev_clk_oe;
  logic interface_clock_output_strap;
  // Pin level: device drive wins, otherwise the board tie
  assign interface_clock_output_strap = dev_clk_oe ? dev_clk : strap_tie;
  modport dev (input active_low_chip_reset_pin_n, input reference_clock_input, input stp,
               input link_data, input link_data_oe, input interface_clock_output_strap,
               output dir, output dev_clk, output dev_clk_oe);
  modport link (output active_low_chip_reset_pin_n, output reference_clock_input, output stp,
                output link_data, output link_data_oe, output strap_tie,
                input dir, input interface_clock_output_strap);
endinterface : urc_if

// file: hdl/urc_timer.sv
// Saturating event counter with terminal flag
`timescale 1ns/100ps
module urc_timer #(
  parameter int W = 8
) (
  input wire logic clk_in, // System clock
  input wire logic srst_in, // Sync reset
  input wire logic clr_in, // Restart count
  input wire logic en_in, // Count one event
  input wire logic [W-1:0] limit_in, // Terminal count
  output logic done_out // Count reached limit
);
  logic [W-1:0] cnt_ff;
  // Saturate so a long wait never wraps back
  always_ff @(posedge clk_in) begin
    if (srst_in || clr_in) begin
      cnt_ff <= '0;
    end else if (en_in && cnt_ff != limit_in) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
  assign done_out = (cnt_ff == limit_in);
endmodule : urc_timer

// file: hdl/urc_device.sv
// Transceiver end: strap, PLL lock, DIR start-up, resets, regulators
`timescale 1ns/100ps
`include "urc_defs.svh"
module urc_device (
  input wire logic clk_in, // 40 MHz system clock
  input wire logic srst_in, // Sync reset, active high
  urc_if.dev bus, // Pins to the link
  input wire logic core_supply_ok_in, // Core supply stable
  input wire logic lowpwr_req_in, // Enter low power
  input wire logic uart_mode_in, // UART mode active
  input wire logic uart_level_we_in, // Write supply level field
  input wire urc_pkg::urc_level_t uart_level_in, // New supply level
  output logic input_mode_out, // Strap picked clock input mode
  output logic pll_locked_out, // PLL lock
  output logic reg_enable_out, // Regulators enabled
  output logic reg_pulldown_out, // Weak pull-down on outputs
  output urc_pkg::urc_level_t supply_level_out, // 3.3V regulator level code
  output logic running_out, // Interface in operation
  output logic session_drop_out // Pulse: session lost
);
  import urc_pkg::*;

  urc_dev_state_t state_ff;
  urc_dev_state_t nxt_state;
  logic supply_ok_ff;
  logic por_pulse;
  logic rst_long_done;
  logic rst_long_ff;
  logic dev_rst;
  logic ref_tick;
  logic ref_prev_ff;
  logic ref_lost;
  logic lock_done;
  logic settle_done;
  logic input_mode_ff;
  urc_level_t uart_level_ff;
  logic dev_clk_ff;
  logic drop_ff;
  logic active_low_chip_reset_pin;

  assign active_low_chip_reset_pin = bus.active_low_chip_reset_pin_n;

  // Power-on pulse on rising core supply
  // Reset level matches a healthy supply, so no false pulse follows reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      supply_ok_ff <= 1'b1;
    end else begin
      supply_ok_ff <= core_supply_ok_in;
    end
  end
  assign por_pulse = core_supply_ok_in && !supply_ok_ff;

  // Reset pin low time, counted in system cycles
  urc_timer #(.W(8)) u_rst_tmr (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .clr_in(active_low_chip_reset_pin),
    .en_in(!active_low_chip_reset_pin),
    .limit_in(8'(`URC_RST_MIN_CYC)),
    .done_out(rst_long_done)
  );

  // Remember a long enough low until the pin is released
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rst_long_ff <= 1'b0;
    end else begin
      rst_long_ff <= !active_low_chip_reset_pin && rst_long_done;
    end
  end
  // Short glitches keep register contents; a full low reloads them
  assign dev_rst = srst_in || por_pulse || (rst_long_ff && active_low_chip_reset_pin);

  // Rising edge of the reference clock is the only event used
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ref_prev_ff <= 1'b0;
    end else begin
      ref_prev_ff <= bus.reference_clock_input;
    end
  end
  assign ref_tick = bus.reference_clock_input && !ref_prev_ff;

  // Watchdog for a stopped reference clock
  urc_timer #(.W(8)) u_loss_tmr (
    .clk_in(clk_in),
    .srst_in(dev_rst),
    .clr_in(ref_tick),
    .en_in(1'b1),
    .limit_in(8'(`URC_LOSS_CYC)),
    .done_out(ref_lost)
  );

  // PLL lock after enough edges; counting starts in DEV_LOCK, after the settle time
  urc_timer #(.W(8)) u_lock_tmr (
    .clk_in(clk_in),
    .srst_in(dev_rst),
    .clr_in(ref_lost || state_ff == DEV_RESET || state_ff == DEV_SETTLE),
    .en_in(ref_tick),
    .limit_in(8'(`URC_LOCK_TICKS)),
    .done_out(lock_done)
  );

  // Internal supplies settle after the regulators come on
  urc_timer #(.W(8)) u_settle_tmr (
    .clk_in(clk_in),
    .srst_in(dev_rst),
    .clr_in(state_ff != DEV_SETTLE),
    .en_in(1'b1),
    .limit_in(8'(`URC_SETTLE_CYC)),
    .done_out(settle_done)
  );

  // Start-up sequence
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DEV_RESET: begin
        // A running clock alone never starts the device
        if (active_low_chip_reset_pin && core_supply_ok_in) begin
          nxt_state = DEV_SETTLE;
        end
      end
      DEV_SETTLE: begin
        if (settle_done) begin
          nxt_state = DEV_LOCK;
        end
      end
      DEV_LOCK: begin
        if (lock_done && !ref_lost) begin
          nxt_state = DEV_STPWAIT;
        end
      end
      DEV_STPWAIT: begin
        if (ref_lost) begin
          nxt_state = DEV_LOCK;
        end else if (!bus.stp) begin
          nxt_state = DEV_RUN;
        end
      end
      DEV_RUN: begin
        if (ref_lost) begin
          nxt_state = DEV_LOCK;
        end else if (lowpwr_req_in) begin
          nxt_state = DEV_LOWPWR;
        end
      end
      DEV_LOWPWR: begin
        // Clock may be absent here; relock after wake
        if (bus.stp) begin
          nxt_state = DEV_LOCK;
        end
      end
      default: begin
        nxt_state = DEV_RESET;
      end
    endcase
    if (!active_low_chip_reset_pin) begin
      nxt_state = DEV_RESET;
    end
  end

  always_ff @(posedge clk_in) begin
    if (dev_rst) begin
      state_ff <= DEV_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Strap caught on the way out of reset, before anyone drives it
  always_ff @(posedge clk_in) begin
    if (dev_rst) begin
      input_mode_ff <= 1'b0;
    end else if (state_ff == DEV_RESET && nxt_state == DEV_SETTLE) begin
      input_mode_ff <= bus.interface_clock_output_strap;
    end
  end

  // Supply level field, defaults on any full reset
  always_ff @(posedge clk_in) begin
    if (dev_rst) begin
      uart_level_ff <= `URC_UART_LVL_RST;
    end else if (uart_level_we_in) begin
      uart_level_ff <= uart_level_in;
    end
  end
  // Level only applies in UART mode; else nominal code
  assign supply_level_out = uart_mode_in ? uart_level_ff : `URC_UART_LVL_RST;

  // Generated interface clock, free of reference phase
  always_ff @(posedge clk_in) begin
    if (dev_rst) begin
      dev_clk_ff <= 1'b0;
    end else if (!input_mode_ff && (state_ff == DEV_STPWAIT || state_ff == DEV_RUN)) begin
      dev_clk_ff <= !dev_clk_ff;
    end else begin
      dev_clk_ff <= 1'b0;
    end
  end
  assign bus.dev_clk = dev_clk_ff;
  // Never drive the strap pin until output mode has locked
  assign bus.dev_clk_oe = !input_mode_ff && (state_ff == DEV_STPWAIT || state_ff == DEV_RUN);

  // Session loss marker when the clock dies mid-session
  always_ff @(posedge clk_in) begin
    if (dev_rst) begin
      drop_ff <= 1'b0;
    end else begin
      drop_ff <= (state_ff == DEV_RUN) && ref_lost;
    end
  end
  assign session_drop_out = drop_ff;

  // DIR low while running or while the reset pin is low; high during lock wait and STP
  assign bus.dir = (state_ff != DEV_RUN) && active_low_chip_reset_pin;
  assign reg_enable_out = active_low_chip_reset_pin;
  assign reg_pulldown_out = !active_low_chip_reset_pin;
  assign input_mode_out = input_mode_ff;
  assign pll_locked_out = lock_done && !ref_lost && state_ff != DEV_RESET;
  assign running_out = (state_ff == DEV_RUN);
endmodule : urc_device

// file: hdl/urc_link.sv
// Link end: reset pin, reference clock, strap tie, start-up and wake
`timescale 1ns/100ps
`include "urc_defs.svh"
module urc_link (
  input wire logic clk_in, // 40 MHz system clock
  input wire logic srst_in, // Sync reset, active high
  urc_if.link bus, // Pins to the transceiver
  input wire logic input_mode_in, // Select clock input mode
  input wire logic enable_in, // Release the transceiver
  input wire logic lowpwr_in, // Request clock stop
  input wire logic reg_write_busy_in, // Register write in flight
  input wire logic wake_in, // Request wake-up
  output logic ready_out, // Interface usable
  output logic clock_running_out // Reference clock running
);
  import urc_pkg::*;

  urc_lnk_state_t state_ff;
  urc_lnk_state_t nxt_state;
  logic [7:0] hold_cnt_ff;
  logic [3:0] wake_cnt_ff;
  logic [3:0] div_cnt_ff;
  logic ref_ff;
  logic clk_run;

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LNK_HOLD: begin
        if (enable_in && hold_cnt_ff >= 8'(`URC_RST_MIN_CYC)) begin
          nxt_state = LNK_START;
        end
      end
      LNK_START: begin
        if (!bus.dir) begin
          nxt_state = LNK_IDLE;
        end
      end
      LNK_IDLE: begin
        nxt_state = LNK_READY;
      end
      LNK_READY: begin
        // Clock stop waits for the last write to finish
        if (lowpwr_in && !reg_write_busy_in) begin
          nxt_state = LNK_STOPPED;
        end
      end
      LNK_STOPPED: begin
        if (wake_in) begin
          nxt_state = LNK_WAKE;
        end
      end
      LNK_WAKE: begin
        // STP stands the minimum time and as long as wake is requested
        if (wake_cnt_ff >= 4'(`URC_WAKE_CYC) && !wake_in) begin
          nxt_state = LNK_START;
        end
      end
      default: begin
        nxt_state = LNK_HOLD;
      end
    endcase
    if (!enable_in) begin
      nxt_state = LNK_HOLD;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_ff <= LNK_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Reset pin low time, saturating
  always_ff @(posedge clk_in) begin
    if (srst_in || state_ff != LNK_HOLD) begin
      hold_cnt_ff <= 8'h00;
    end else if (hold_cnt_ff != 8'hff) begin
      hold_cnt_ff <= hold_cnt_ff + 8'h01;
    end
  end

  // STP pulse length on wake; saturates so a long wake never wraps
  always_ff @(posedge clk_in) begin
    if (srst_in || state_ff != LNK_WAKE) begin
      wake_cnt_ff <= 4'h0;
    end else if (wake_cnt_ff != 4'hf) begin
      wake_cnt_ff <= wake_cnt_ff + 4'h1;
    end
  end

  // Reference clock divider; restarts with STP on wake
  assign clk_run = (state_ff != LNK_STOPPED);
  always_ff @(posedge clk_in) begin
    if (srst_in || !clk_run) begin
      div_cnt_ff <= 4'h0;
      ref_ff <= 1'b0;
    end else if (div_cnt_ff == 4'(`URC_REFERENCE_CLOCK_INPUT_DIV - 1)) begin
      div_cnt_ff <= 4'h0;
      ref_ff <= !ref_ff;
    end else begin
      div_cnt_ff <= div_cnt_ff + 4'h1;
    end
  end

  // Reset pin always driven to a defined level
  assign bus.active_low_chip_reset_pin_n = (state_ff != LNK_HOLD);
  assign bus.reference_clock_input = ref_ff;
  assign bus.strap_tie = input_mode_in;
  assign bus.stp = (state_ff == LNK_WAKE);
  assign bus.link_data = `URC_BUS_IDLE;
  // Never fight the device while it owns the bus
  assign bus.link_data_oe = ((state_ff == LNK_IDLE) || (state_ff == LNK_READY)) && !bus.dir;
  assign ready_out = (state_ff == LNK_READY);
  assign clock_running_out = clk_run;
endmodule : urc_link

// file: verif/urc_properties.sv
// Checker on the pins between transceiver and link
`timescale 1ns/100ps
`include "urc_defs.svh"
module urc_properties (
  input wire logic clk_in, // Clock
  input wire logic srst_in, // Sync reset
  input wire logic active_low_chip_reset_pin_n, // Reset pin
  input wire logic reference_clock_input, // Ref clock
  input wire logic stp, // Stop
  input wire logic dir, // Direction
  input wire urc_pkg::urc_byte_t link_data, // Data bus
  input wire logic link_data_oe, // Link drives bus
  input wire logic strap_tie, // Strap tie
  input wire logic dev_clk, // Made clock
  input wire logic dev_clk_oe, // Made clock driven
  input wire logic interface_clock_output_strap // Strap pin
);
  import urc_pkg::*;
  logic rn;
  logic ref_q_ff;
  logic [7:0] low_ff;
  logic [7:0] quiet_ff;
  logic [7:0] rise_ff;
  assign rn = active_low_chip_reset_pin_n;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // Last ref level, for edge detection
  always_ff @(posedge clk_in) begin
    ref_q_ff <= reference_clock_input;
  end
  // Low time of reset pin; saturates so it never wraps
  always_ff @(posedge clk_in) begin
    if (srst_in || rn) begin
      low_ff <= 8'h00;
    end else if (low_ff != 8'hff) begin
      low_ff <= low_ff + 8'h01;
    end
  end
  // Cycles since the ref clock last moved
  always_ff @(posedge clk_in) begin
    if (srst_in || reference_clock_input != ref_q_ff) begin
      quiet_ff <= 8'h00;
    end else if (quiet_ff != 8'hff) begin
      quiet_ff <= quiet_ff + 8'h01;
    end
  end
  // Rising ref edges since reset pin release
  always_ff @(posedge clk_in) begin
    if (srst_in || !rn) begin
      rise_ff <= 8'h00;
    end else if (reference_clock_input && !ref_q_ff && rise_ff != 8'hff) begin
      rise_ff <= rise_ff + 8'h01;
    end
  end
  property p_rel; $rose(rn) |-> dir [*8]; endproperty
  a_rel: assert property (p_rel) else $error("dir low after release");
  property p_stp; stp && dir && rn |=> dir || !rn; endproperty
  a_stp: assert property (p_stp) else $error("dir fell with stp high");
  property p_idle; $fell(dir) && rn |=> link_data_oe && link_data == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("bus not idle");
  property p_clk; $fell(dir) && rn && !strap_tie |-> dev_clk_oe && interface_clock_output_strap == dev_clk;
  endproperty
  a_clk: assert property (p_clk) else $error("clock not driven");
  property p_quiet; !rn && $past(!rn) |-> !dir && !dev_clk_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("active in reset");
  // Margin of a few cycles past the loss count for the state change
  property p_loss; quiet_ff >= 8'(`URC_LOSS_CYC + 4) && rn |-> dir; endproperty
  a_loss: assert property (p_loss) else $error("no lock loss");
  property p_edges; $fell(dir) && rn |-> rise_ff >= 8'(`URC_LOCK_TICKS); endproperty
  a_edges: assert property (p_edges) else $error("early lock");
  property p_width; $rose(rn) |-> low_ff >= 8'(`URC_RST_MIN_CYC); endproperty
  a_width: assert property (p_width) else $error("reset too short");
  c_start: cover property ($fell(dir) && rn);
  c_wake: cover property ($rose(stp));
  c_loss: cover property (quiet_ff == 8'(`URC_LOSS_CYC + 4) && rn);
endmodule : urc_properties

// file: verif/tb_top.sv
// Bench joining both ends of the clock and reset control
`timescale 1ns/100ps
module tb_top;
  import urc_pkg::*;
  logic clk_in, srst_in, ok, lpq, um, we, mode, en, lp, busy, wake;
  logic im, lck, ren, rpd, run, drop, rdy, crun;
  urc_level_t lvl, level;
  int n_errors = 0;
  int num_checks = 0;
  urc_if pins ();
  urc_device i_urc_device (.clk_in(clk_in), .srst_in(srst_in), .bus(pins), .core_supply_ok_in(ok),
    .lowpwr_req_in(lpq), .uart_mode_in(um), .uart_level_we_in(we), .uart_level_in(lvl),
    .input_mode_out(im), .pll_locked_out(lck), .reg_enable_out(ren), .reg_pulldown_out(rpd),
    .supply_level_out(level), .running_out(run), .session_drop_out(drop));
  urc_link i_urc_link (.clk_in(clk_in), .srst_in(srst_in), .bus(pins), .input_mode_in(mode),
    .enable_in(en), .lowpwr_in(lp), .reg_write_busy_in(busy), .wake_in(wake), .ready_out(rdy),
    .clock_running_out(crun));
  urc_properties i_urc_properties (.clk_in(clk_in), .srst_in(srst_in),
    .active_low_chip_reset_pin_n(pins.active_low_chip_reset_pin_n),
    .reference_clock_input(pins.reference_clock_input), .stp(pins.stp), .dir(pins.dir),
    .link_data(pins.link_data), .link_data_oe(pins.link_data_oe), .strap_tie(pins.strap_tie),
    .dev_clk(pins.dev_clk), .dev_clk_oe(pins.dev_clk_oe),
    .interface_clock_output_strap(pins.interface_clock_output_strap));
  // 40 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // Inputs move 1 ns after the edge, clear of sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  // Bounded wait for the device to run
  task automatic wait_run();
    for (int i = 0; i < 400 && (run !== 1'b1 || rdy !== 1'b1); i++) begin
      cyc(1);
    end
    check("running", 8'(run), 8'h01);
    check("ready", 8'(rdy), 8'h01);
  endtask : wait_run
  // Hold in reset with clock running, then start in mode m
  task automatic t_start(input logic m);
    en = 1'b0;
    cyc(45);
    check("dir", 8'(pins.dir), 8'h00);
    check("run", 8'(run), 8'h00);
    check("reg_en", 8'(ren), 8'h00);
    check("reg_pd", 8'(rpd), 8'h01);
    mode = m;
    cyc(2);
    en = 1'b1;
    wait_run();
    check("mode", 8'(im), 8'(m));
    check("lock", 8'(lck), 8'h01);
    check("reg_en", 8'(ren), 8'h01);
    check("clk_oe", 8'(pins.dev_clk_oe), 8'(!m));
    $display("start mode %0d done", m);
  endtask : t_start
  // Wake with stp; dir must wait for stp to drop
  task automatic t_wake();
    lpq = 1'b0;
    lp = 1'b0;
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
    cyc(1);
    check("stp", 8'(pins.stp), 8'h01);
    check("dir", 8'(pins.dir), 8'h01);
    check("clk_run", 8'(crun), 8'h01);
    wait_run();
  endtask : t_wake
  // Clock stop waits for the register write to finish
  task automatic t_lowpwr();
    lpq = 1'b1;
    cyc(3);
    check("dir", 8'(pins.dir), 8'h01);
    busy = 1'b1;
    lp = 1'b1;
    cyc(20);
    check("clk_run", 8'(crun), 8'h01);
    busy = 1'b0;
    cyc(20);
    check("clk_run", 8'(crun), 8'h00);
    t_wake();
    $display("low power done");
  endtask : t_lowpwr
  // Clock stopped while running drops the session
  task automatic t_loss();
    lp = 1'b1;
    for (int i = 0; i < 60 && drop !== 1'b1; i++) begin
      cyc(1);
    end
    check("drop", 8'(drop), 8'h01);
    cyc(1);
    check("drop", 8'(drop), 8'h00);
    check("lock", 8'(lck), 8'h00);
    check("dir", 8'(pins.dir), 8'h01);
    t_wake();
    $display("loss done");
  endtask : t_loss
  // Every level code; ends with 2'h3 held in UART mode
  task automatic t_level();
    um = 1'b1;
    we = 1'b1;
    for (int v = 0; v < 4; v++) begin
      lvl = urc_level_t'(v);
      cyc(1);
      check("level", 8'(level), 8'(v));
    end
    we = 1'b0;
    um = 1'b0;
    cyc(1);
    check("level", 8'(level), 8'h00);
    um = 1'b1;
    cyc(1);
    $display("level done");
  endtask : t_level
  // Supply rise restarts the device and reloads defaults
  task automatic t_por();
    t_level();
    ok = 1'b0;
    cyc(4);
    ok = 1'b1;
    cyc(3);
    check("run", 8'(run), 8'h00);
    check("level", 8'(level), 8'h00);
    wait_run();
    $display("power-on done");
  endtask : t_por
  // Long STP: device relocks but keeps dir high until STP drops
  task automatic t_stp_hold();
    lpq = 1'b1;
    lp = 1'b1;
    cyc(20);
    check("clk_run", 8'(crun), 8'h00);
    lpq = 1'b0;
    lp = 1'b0;
    wake = 1'b1;
    cyc(150);
    check("lock", 8'(lck), 8'h01);
    check("stp", 8'(pins.stp), 8'h01);
    check("dir", 8'(pins.dir), 8'h01);
    check("run", 8'(run), 8'h00);
    wake = 1'b0;
    wait_run();
    $display("stp hold done");
  endtask : t_stp_hold
  // Watchdog: the tests need under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    end_sim();
  end
  initial begin
    srst_in = 1'b1;
    {ok, lpq, um, we, mode, en, lp, busy, wake} = 9'h100;
    lvl = 2'h0;
    repeat (12) @(posedge clk_in);
    #1;
    srst_in = 1'b0;
    t_start(1'b0);
    t_lowpwr();
    t_loss();
    t_stp_hold();
    t_level();
    t_start(1'b1);
    check("level", 8'(level), 8'h00);
    t_por();
    end_sim();
  end
endmodule : tb_top
